// ==== rtl/pwm_period_pkg.sv ====
// constants for the buffered period update block
// assumes one 100 MHz clock and a plain register port
package pwm_period_pkg;
  localparam int CLK_MHZ = 100;
  localparam logic [11:0] PERIOD_UPDATE_BASE = 12'h210;
  localparam logic [11:0] CHANNEL_STRIDE = 12'h020;
  localparam logic [11:0] CLOCK_CFG_OFF = 12'h300;
  localparam logic [11:0] PROTECT_OFF = 12'h304;
  localparam logic [11:0] SPREAD_OFF = 12'h308;
  localparam logic [11:0] MODE_OFF = 12'h30C;
  localparam logic [11:0] STATUS_OFF = 12'h310;
  localparam logic [11:0] ACTIVE_BASE = 12'h320;
  localparam int UPDATE_FIELD_MSB = 23;
  localparam int PRESCALE_MAX_EXP = 10;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // mode register: bit0 centre aligned, bits2:1 divider select
  localparam int MODE_CENTRE_BIT = 0;
  localparam int MODE_DIV_LSB = 1;
  localparam logic [1:0] DIV_NONE = 2'h0;
  localparam logic [1:0] DIV_FIRST = 2'h1;
  localparam logic [1:0] DIV_SECOND = 2'h2;
  // clock config: 3:0 prescaler exponent, 15:8 first divider, 23:16 second divider
  localparam int PRESCALE_EXP_LSB = 0;
  localparam int CLK_DIV_FIRST_LSB = 8;
  localparam int CLK_DIV_SECOND_LSB = 16;
endpackage

// ==== rtl/pwm_period_update_buffer.sv ====
// double-buffered period update path for a four channel pwm counter bank
// assumes synchronous inputs, master never waits, read data one cycle after strobe
module pwm_period_update_buffer #(
  parameter int CHANNELS = 4,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // hardware protect flag from outside
  input wire logic hw_protect_group3_flag,
  // waveform outputs and period ends
  output logic [CHANNELS-1:0] pwm_out,
  output logic [CHANNELS-1:0] period_end
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 4 || CNT_W != 16) $error("unsupported parameters");
  end

  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic [CNT_W-1:0] update_reg [CHANNELS];
  logic [CNT_W-1:0] active_period_reg [CHANNELS];
  logic [CNT_W-1:0] cnt_reg [CHANNELS];
  logic [CHANNELS-1:0] down_reg;
  logic [CHANNELS-1:0] end_next;
  logic [31:0] clk_cfg_reg;
  logic [2:0] mode_reg;
  logic sw_protect_group3_flag;
  logic [CNT_W-1:0] spread_range;
  logic [CNT_W-1:0] spread_cnt_reg;
  logic spread_down_reg;
  logic [10:0] pre_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic tick_reg;
  logic pre_tick;
  logic [3:0] prescaler_exponent;
  logic [7:0] clock_divider_first;
  logic [7:0] clock_divider_second;
  logic [7:0] div_sel;
  logic [CNT_W-1:0] eff_period [CHANNELS];
  logic [10:0] pre_mask;

  function automatic logic hit_channel(input logic [11:0] a, input logic [11:0] base,
                                       input int ch);
    hit_channel = (a == 12'(base + 12'(ch) * pwm_period_pkg::CHANNEL_STRIDE));
  endfunction

  assign prescaler_exponent = clk_cfg_reg[pwm_period_pkg::PRESCALE_EXP_LSB +: 4];
  assign clock_divider_first = clk_cfg_reg[pwm_period_pkg::CLK_DIV_FIRST_LSB +: 8];
  assign clock_divider_second = clk_cfg_reg[pwm_period_pkg::CLK_DIV_SECOND_LSB +: 8];

  // exponents above the maximum clamp to the 1024 prescale
  always_comb begin
    if (prescaler_exponent > 4'(pwm_period_pkg::PRESCALE_MAX_EXP)) begin
      pre_mask = 11'h3FF;
    end else begin
      pre_mask = 11'((11'h001 << prescaler_exponent) - 11'h001);
    end
  end

  always_comb begin
    unique case (mode_reg[pwm_period_pkg::MODE_DIV_LSB +: 2])
      pwm_period_pkg::DIV_FIRST: div_sel = clock_divider_first;
      pwm_period_pkg::DIV_SECOND: div_sel = clock_divider_second;
      default: div_sel = 8'h01;
    endcase
  end

  // prescaler: one tick every 2^exponent clocks
  assign pre_tick = ((pre_cnt_reg & pre_mask) == pre_mask);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_cnt_reg <= 11'h000;
    end else begin
      pre_cnt_reg <= 11'(pre_cnt_reg + 11'h001);
    end
  end

  // optional divider after the prescaler; zero divider treated as one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (pre_tick) begin
        if (div_cnt_reg + 8'h01 >= div_sel) begin
          div_cnt_reg <= 8'h00;
          tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= 8'(div_cnt_reg + 8'h01);
        end
      end
    end
  end

  // channel 0 effective period rises by up to spread_range above its active period
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      eff_period[c] = active_period_reg[c];
    end
    eff_period[0] = CNT_W'(active_period_reg[0] + spread_cnt_reg);
  end

  // triangle spread counter, advanced once per channel 0 period
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spread_cnt_reg <= pwm_period_pkg::PERIOD_RESET;
      spread_down_reg <= 1'b0;
    end else if (spread_cnt_reg > spread_range) begin
      spread_cnt_reg <= spread_range;
    end else if (end_next[0]) begin
      if (spread_range == '0) begin
        spread_cnt_reg <= '0;
      end else if (!spread_down_reg && spread_cnt_reg == spread_range) begin
        spread_down_reg <= 1'b1;
        spread_cnt_reg <= CNT_W'(spread_cnt_reg - ONE);
      end else if (spread_down_reg && spread_cnt_reg == '0) begin
        spread_down_reg <= 1'b0;
        spread_cnt_reg <= ONE;
      end else if (spread_down_reg) begin
        spread_cnt_reg <= CNT_W'(spread_cnt_reg - ONE);
      end else begin
        spread_cnt_reg <= CNT_W'(spread_cnt_reg + ONE);
      end
    end
  end

  // period end: left aligned wraps at period, centre aligned returns to zero
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (mode_reg[pwm_period_pkg::MODE_CENTRE_BIT]) begin
        end_next[c] = tick_reg && down_reg[c] && cnt_reg[c] <= ONE;
      end else begin
        end_next[c] = tick_reg && cnt_reg[c] + ONE >= eff_period[c];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        cnt_reg[c] <= '0;
      end
      down_reg <= '0;
    end else if (tick_reg) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (!mode_reg[pwm_period_pkg::MODE_CENTRE_BIT]) begin
          down_reg[c] <= 1'b0;
          cnt_reg[c] <= end_next[c] ? '0 : CNT_W'(cnt_reg[c] + ONE);
        end else if (end_next[c]) begin
          down_reg[c] <= 1'b0;
          cnt_reg[c] <= '0;
        end else if (!down_reg[c] && cnt_reg[c] + ONE >= eff_period[c]) begin
          down_reg[c] <= 1'b1;
          cnt_reg[c] <= eff_period[c];
        end else if (down_reg[c]) begin
          cnt_reg[c] <= CNT_W'(cnt_reg[c] - ONE);
        end else begin
          cnt_reg[c] <= CNT_W'(cnt_reg[c] + ONE);
        end
      end
    end
  end

  // waveform high during the first half of the count range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwm_out <= '0;
      period_end <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        pwm_out[c] <= cnt_reg[c] < (eff_period[c] >> 1);
      end
      period_end <= end_next;
    end
  end

  // buffered update, taken only when unprotected; low 16 bits used
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        update_reg[c] <= pwm_period_pkg::PERIOD_RESET;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (reg_wr && hit_channel(reg_addr, pwm_period_pkg::PERIOD_UPDATE_BASE, c)
            && !sw_protect_group3_flag && !hw_protect_group3_flag) begin
          update_reg[c] <= reg_wdata[CNT_W-1:0];
        end
      end
    end
  end

  // active period loads at the period boundary, or at once while it is zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        active_period_reg[c] <= pwm_period_pkg::PERIOD_RESET;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (end_next[c] || active_period_reg[c] == '0) begin
          active_period_reg[c] <= update_reg[c];
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_cfg_reg <= pwm_period_pkg::READ_ZERO;
      mode_reg <= 3'h0;
      sw_protect_group3_flag <= 1'b0;
      spread_range <= pwm_period_pkg::PERIOD_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        pwm_period_pkg::CLOCK_CFG_OFF: clk_cfg_reg <= {8'h00, reg_wdata[23:0]};
        pwm_period_pkg::MODE_OFF: mode_reg <= reg_wdata[2:0];
        pwm_period_pkg::PROTECT_OFF: sw_protect_group3_flag <= reg_wdata[0];
        pwm_period_pkg::SPREAD_OFF: spread_range <= reg_wdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // read port; update registers are write-only and read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= pwm_period_pkg::READ_ZERO;
    end else begin
      reg_rdata <= pwm_period_pkg::READ_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          pwm_period_pkg::CLOCK_CFG_OFF: reg_rdata <= clk_cfg_reg;
          pwm_period_pkg::MODE_OFF: reg_rdata <= {29'h0, mode_reg};
          pwm_period_pkg::PROTECT_OFF: reg_rdata <= {31'h0, sw_protect_group3_flag};
          pwm_period_pkg::SPREAD_OFF: reg_rdata <= {16'h0, spread_range};
          pwm_period_pkg::STATUS_OFF: reg_rdata <= {16'h0, spread_cnt_reg};
          default: begin
            for (int c = 0; c < CHANNELS; c++) begin
              if (hit_channel(reg_addr, pwm_period_pkg::ACTIVE_BASE, c)) begin
                reg_rdata <= {16'h0, active_period_reg[c]};
              end
            end
          end
        endcase
      end
    end
  end

  property p_protect_blocks;
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && hit_channel(reg_addr, pwm_period_pkg::PERIOD_UPDATE_BASE, 1)
     && (hw_protect_group3_flag || sw_protect_group3_flag)) |=> $stable(update_reg[1]);
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) else $error("protected write taken");

  property p_write_taken;
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == pwm_period_pkg::PERIOD_UPDATE_BASE && !hw_protect_group3_flag
     && !sw_protect_group3_flag) |=> update_reg[0] == $past(reg_wdata[15:0]);
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("update not stored");

  property p_active_holds;
    @(posedge sys_clk) disable iff (srst)
    (!end_next[0] && active_period_reg[0] != '0) |=> $stable(active_period_reg[0]);
  endproperty
  a_active_holds: assert property (p_active_holds) else $error("period changed mid-cycle");

  property p_load_at_end;
    @(posedge sys_clk) disable iff (srst)
    end_next[1] |=> active_period_reg[1] == $past(update_reg[1]);
  endproperty
  a_load_at_end: assert property (p_load_at_end) else $error("no load at boundary");

  property p_spread_bound;
    @(posedge sys_clk) disable iff (srst)
    $stable(spread_range) && $past(spread_cnt_reg <= spread_range) |-> spread_cnt_reg <= spread_range;
  endproperty
  a_spread_bound: assert property (p_spread_bound) else $error("spread out of range");

  property p_spread_step;
    @(posedge sys_clk) disable iff (srst)
    (end_next[0] && spread_range > 16'h0001 && spread_cnt_reg < spread_range
     && !spread_down_reg && $stable(spread_range)) |=> spread_cnt_reg == $past(spread_cnt_reg) + 16'h0001;
  endproperty
  a_spread_step: assert property (p_spread_step) else $error("spread stalled");

  sequence s_tick_left;
    tick_reg && !mode_reg[pwm_period_pkg::MODE_CENTRE_BIT];
  endsequence
  property p_left_count;
    @(posedge sys_clk) disable iff (srst)
    s_tick_left ##0 (!end_next[1] && !srst) |=> cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001;
  endproperty
  a_left_count: assert property (p_left_count) else $error("left count wrong");

  property p_centre_turn;
    @(posedge sys_clk) disable iff (srst)
    (tick_reg && mode_reg[pwm_period_pkg::MODE_CENTRE_BIT] && end_next[3])
      |=> cnt_reg[3] == '0 && !down_reg[3];
  endproperty
  a_centre_turn: assert property (p_centre_turn) else $error("centre end wrong");
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the buffered period update block
// assumes the design's 100 MHz clock, sync reset and one-cycle register strobes
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic hw_protect_group3_flag = 1'b0;
  logic [3:0] pwm_out;
  logic [3:0] period_end;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  int p;
  int n;
  int div;
  int lo;
  int hi;

  pwm_period_update_buffer #(.CHANNELS(4), .CNT_W(16)) i_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .hw_protect_group3_flag(hw_protect_group3_flag),
    .pwm_out(pwm_out),
    .period_end(period_end)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe, so sample exactly there
  always @(posedge sys_clk) begin
    if (rd_pend) begin
      check(reg_rdata, exp_q.pop_front());
    end
    rd_pend <= reg_rd;
  end

  function automatic logic [11:0] upd(input int ch);
    return pwm_period_pkg::PERIOD_UPDATE_BASE + pwm_period_pkg::CHANNEL_STRIDE * 12'(ch);
  endfunction

  function automatic logic [11:0] act(input int ch);
    return pwm_period_pkg::ACTIVE_BASE + pwm_period_pkg::CHANNEL_STRIDE * 12'(ch);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_end(input int ch);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (period_end[ch] !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 20000) begin
      check(32'h0000_0000, 32'h0000_0001);
    end
  endtask

  // skip two boundaries so a config change mid-period does not skew the count
  task automatic measure(input int ch, output int cyc);
    wait_end(ch);
    wait_end(ch);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (period_end[ch] !== 1'b1 && cyc < 20000);
  endtask

  initial begin
    #800000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h61E9D352));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    rd(act(1), 32'h0000_0000);
    rd(12'hFFC, 32'h0000_0000);
    // update bits 23:16 are random and must not reach the period
    wr(upd(1), {8'h00, 8'($urandom), 16'd1000});
    rd(act(1), 32'd1000);
    wr(pwm_period_pkg::PROTECT_OFF, 32'h0000_0001);
    rd(pwm_period_pkg::PROTECT_OFF, 32'h0000_0001);
    wr(upd(1), 32'd5);
    wait_end(1);
    wait_end(1);
    rd(act(1), 32'd1000);
    wr(pwm_period_pkg::PROTECT_OFF, 32'h0000_0000);
    @(posedge sys_clk);
    hw_protect_group3_flag <= 1'b1;
    wr(upd(1), 32'd6);
    wait_end(1);
    wait_end(1);
    rd(act(1), 32'd1000);
    @(posedge sys_clk);
    hw_protect_group3_flag <= 1'b0;
    p = 2 + ($urandom % 8);
    wait_end(1);
    wr(upd(1), 32'(p));
    rd(act(1), 32'd1000);
    wait_end(1);
    rd(act(1), 32'(p));
    // prescale exponent 1, first divider 3, second divider 5
    wr(pwm_period_pkg::CLOCK_CFG_OFF, 32'h0005_0301);
    for (int m = 0; m < 6; m++) begin
      div = (m / 2 == 0) ? 1 : ((m / 2 == 1) ? 3 : 5);
      wr(pwm_period_pkg::MODE_OFF, 32'(m));
      measure(1, n);
      check(32'(n), 32'(p * 2 * div * ((m % 2) + 1)));
    end
    wr(pwm_period_pkg::MODE_OFF, 32'h0000_0000);
    wr(pwm_period_pkg::CLOCK_CFG_OFF, 32'h0000_000A);
    measure(1, n);
    check(32'(n), 32'(p * 1024));
    wr(pwm_period_pkg::CLOCK_CFG_OFF, 32'h0000_0000);
    wr(pwm_period_pkg::SPREAD_OFF, 32'h0000_0003);
    wr(upd(0), 32'd20);
    lo = 100000;
    hi = 0;
    for (int i = 0; i < 8; i++) begin
      measure(0, n);
      lo = (n < lo) ? n : lo;
      hi = (n > hi) ? n : hi;
    end
    check({31'h0, lo >= 20 && hi <= 23}, 32'h0000_0001);
    check({31'h0, hi > lo}, 32'h0000_0001);
    measure(1, n);
    check(32'(n), 32'(p));
    // waveform is periodic, so any window of one period holds the same high count
    lo = 0;
    repeat (p) begin
      @(posedge sys_clk);
      if (pwm_out[1] === 1'b1) begin
        lo++;
      end
    end
    check(32'(lo), 32'(p / 2));
    repeat (4) @(posedge sys_clk);
    check(32'(exp_q.size()), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
